/* File: plk_pkg.sv */
package plk_pkg;
  // register byte addresses (index times four)
  localparam logic [3:0] IDX_LOCK = 4'h7;
  localparam logic [3:0] IDX_ANA = 4'h8;
  localparam logic [3:0] IDX_CP = 4'h9;
  localparam logic [3:0] IDX_AUX = 4'ha;
  localparam logic [7:0] ADDR_LOCK = 8'h1c;
  localparam logic [7:0] ADDR_ANA = 8'h20;
  localparam logic [7:0] ADDR_CP = 8'h24;
  localparam logic [7:0] ADDR_AUX = 8'h28;
  localparam logic [7:0] ADDR_STAT = 8'h40;
  localparam logic [7:0] ADDR_MASK = 8'h44;
  localparam logic [7:0] ADDR_LSTAT = 8'h48;
  localparam logic [7:0] ADDR_PADCTL = 8'h4c;
  // reset values
  localparam logic [13:0] RST_LOCK = 14'h000d;
  localparam logic [23:0] RST_ANA = 24'hc1beff;
  localparam logic [23:0] RST_CP = 24'h40050a;
  localparam logic [23:0] RST_AUX = 24'h002205;
  // lock register fields
  localparam int LK_THR_LO = 0;
  localparam int LK_EN = 3;
  localparam int LK_WTYPE = 6;
  localparam int LK_WDUR_LO = 7;
  localparam int LK_TRATE_LO = 10;
  localparam int LK_TTEST = 12;
  localparam int LK_RELOCK = 13;
  // analog / charge pump fields
  localparam int AN_PAD_EN = 5;
  localparam int AN_RFB_LO = 12;
  localparam int AN_RSY_LO = 15;
  localparam int AN_DIV2 = 19;
  localparam int CP_DN_LO = 0;
  localparam int CP_UP_LO = 7;
  localparam int CP_OFS_LO = 14;
  localparam int CP_OFS_UP = 21;
  localparam int CP_OFS_DN = 22;
  localparam int CP_HIK = 23;
  // pad control: bit 1 selects lock/gpo, bit 0 is the gpo level
  localparam int PC_LDSEL = 1;
  localparam int PC_GPO = 0;
  // interrupt status bits
  localparam int IRQ_LOCK = 0;
  localparam int IRQ_LOSS = 1;
  localparam int IRQ_RELOCK = 2;
  // analog one-shot window, ns, and its full width in cycles, at least one
  localparam int ANA_WIN_NS = 10;
  localparam int CLK_NS = 25;
  localparam int ANA_WIN_CYC = (ANA_WIN_NS / CLK_NS) < 1 ? 1 :
                                (ANA_WIN_NS / CLK_NS);
  localparam logic [2:0] BIAS_OFF = 3'h0;
  localparam logic [31:0] RESP_OKAY = 32'h0;
  typedef enum logic [2:0] {
    LK_IDLE = 3'b001,
    LK_HUNT = 3'b010,
    LK_LOCKED = 3'b100
  } plk_state_t;
endpackage

/* File: plk_top.sv */
`timescale 1ns/1ps
// How it works
// - lock after threshold consecutive in-window hits
// - detection runs only while enable set
// - window type picks digital timer or one-shot
// - digital window length from duration field
// - timer rate field, 00 fastest
// - test bit runs timer continuously
// - auto relock tries at most once until its enable bit is cleared
// - pad enable and select steer status pin
// - bias fields, zero disables the block
// - divide-by-two path follows its enable
// - pump up/down gain, 20 uA per code
// - offset current, 5 uA per code
// - offset direction bits up and down
// - high gain pump mode select
module plk_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // pll events
  input wire logic ref_evt,
  input wire logic vco_evt,
  input wire logic serial_data,
  input wire logic serial_drive,
  // status pad
  output logic lock_serial_out_pin,
  output logic lock_serial_out_pin_oe,
  // analog controls
  output logic [23:0] analog_enable_out,
  output logic [23:0] charge_pump_out,
  output logic [23:0] aux_trigger_out,
  output logic divide_by_two_on,
  output logic rf_buffer_on,
  output logic resync_on,
  output logic [6:0] pump_down_gain,
  output logic [6:0] pump_up_gain,
  output logic [6:0] offset_up_code,
  output logic [6:0] offset_down_code,
  output logic high_gain_pump_mode,
  output logic relock_req,
  output logic locked,
  output logic irq
);
  logic [13:0] lock_detect_config_reg;
  logic [23:0] analog_enable_config_reg;
  logic [23:0] charge_pump_config_reg;
  logic [23:0] aux_serial_trigger_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  logic [1:0] pad_ctl_reg;
  logic [7:0] addr_reg;
  logic wr_reg;
  logic [16:0] hits_reg;
  logic tried_reg;
  logic ref_seen_reg;
  plk_pkg::plk_state_t st_reg;
  plk_pkg::plk_state_t st_next;
  // output staging
  logic pad_reg;
  logic pad_oe_reg;
  logic div2_reg;
  logic rfb_reg;
  logic rsy_reg;
  logic [6:0] ofs_up_reg;
  logic [6:0] ofs_dn_reg;
  logic relock_reg;
  logic irq_reg;
  logic [31:0] rdata_reg;

  function automatic logic [16:0] thr_count(input logic [2:0] c);
    case (c)
      3'h0: thr_count = 17'h00005;
      3'h1: thr_count = 17'h00020;
      3'h2: thr_count = 17'h00060;
      3'h3: thr_count = 17'h00100;
      3'h4: thr_count = 17'h00200;
      3'h5: thr_count = 17'h00800;
      3'h6: thr_count = 17'h02000;
      default: thr_count = 17'h0ffff;
    endcase
  endfunction

  function automatic logic [23:0] w1c(input logic [23:0] v);
    w1c = v;
  endfunction

  // bus decode
  wire addr_ok = hsel && hready && htrans[1];
  wire do_wr = wr_reg;
  wire [2:0] thr_sel = lock_detect_config_reg[plk_pkg::LK_THR_LO +: 3];
  wire ld_en = lock_detect_config_reg[plk_pkg::LK_EN];
  wire win_dig = lock_detect_config_reg[plk_pkg::LK_WTYPE];
  wire [2:0] win_dur = lock_detect_config_reg[plk_pkg::LK_WDUR_LO +: 3];
  wire [1:0] win_rate = lock_detect_config_reg[plk_pkg::LK_TRATE_LO +: 2];
  wire win_cont = lock_detect_config_reg[plk_pkg::LK_TTEST];
  wire relock_en = lock_detect_config_reg[plk_pkg::LK_RELOCK];
  wire win_open;

  plk_window #(.CW(8)) u_win (
    .core_clk(core_clk),
    .rst(rst),
    .ref_evt(ref_evt),
    .digital(win_dig),
    .dur(win_dur),
    .rate(win_rate),
    .cont(win_cont),
    .open_now(win_open)
  );

  // lock detection
  wire hit = vco_evt && win_open;
  wire miss = vco_evt && !win_open && ref_seen_reg;
  wire [16:0] thr = thr_count(thr_sel);
  wire reached = hit && (hits_reg + 17'h1 >= thr);
  wire lost = (st_reg == plk_pkg::LK_LOCKED) && (miss || !ld_en);
  wire gain = (st_reg == plk_pkg::LK_HUNT) && reached;
  wire fire_relock = lost && relock_en && !tried_reg;

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      plk_pkg::LK_IDLE: begin
        if (ld_en) st_next = plk_pkg::LK_HUNT;
      end
      plk_pkg::LK_HUNT: begin
        if (!ld_en) st_next = plk_pkg::LK_IDLE;
        else if (reached) st_next = plk_pkg::LK_LOCKED;
      end
      plk_pkg::LK_LOCKED: begin
        if (!ld_en) st_next = plk_pkg::LK_IDLE;
        else if (miss) st_next = plk_pkg::LK_HUNT;
      end
      default: st_next = plk_pkg::LK_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_reg <= plk_pkg::LK_IDLE;
      hits_reg <= 17'h0;
      ref_seen_reg <= 1'b0;
      tried_reg <= 1'b0;
      relock_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      if (ref_evt) ref_seen_reg <= 1'b1;
      if (!ld_en || miss) hits_reg <= 17'h0;
      else if (hit && hits_reg != thr) hits_reg <= hits_reg + 17'h1;
      if (fire_relock) tried_reg <= 1'b1;
      else if (!relock_en) tried_reg <= 1'b0;
      relock_reg <= fire_relock;
    end
  end

  // ahb-lite address and data phase
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      addr_reg <= 8'h00;
      wr_reg <= 1'b0;
    end else begin
      addr_reg <= haddr;
      wr_reg <= addr_ok && hwrite;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lock_detect_config_reg <= plk_pkg::RST_LOCK;
      analog_enable_config_reg <= plk_pkg::RST_ANA;
      charge_pump_config_reg <= plk_pkg::RST_CP;
      aux_serial_trigger_reg <= plk_pkg::RST_AUX;
      irq_mask_reg <= 3'h0;
      pad_ctl_reg <= 2'h0;
    end else if (do_wr) begin
      case (addr_reg)
        plk_pkg::ADDR_LOCK: lock_detect_config_reg <= hwdata[13:0];
        plk_pkg::ADDR_ANA: analog_enable_config_reg <= hwdata[23:0];
        plk_pkg::ADDR_CP: charge_pump_config_reg <= hwdata[23:0];
        plk_pkg::ADDR_AUX: aux_serial_trigger_reg <= hwdata[23:0];
        plk_pkg::ADDR_MASK: irq_mask_reg <= hwdata[2:0];
        plk_pkg::ADDR_PADCTL: pad_ctl_reg <= hwdata[1:0];
        default: ;
      endcase
    end
  end

  // sticky events, set beats write-one clear
  wire [2:0] ev = {fire_relock, lost, gain};
  wire clr_hit = do_wr && addr_reg == plk_pkg::ADDR_STAT;
  wire [2:0] clr = clr_hit ? hwdata[2:0] : 3'h0;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_stat_reg <= 3'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~clr) | ev;
    end
  end

  // read mux, unmapped reads zero
  wire [31:0] rd_mux =
    (haddr == plk_pkg::ADDR_LOCK) ? {18'h0, lock_detect_config_reg} :
    (haddr == plk_pkg::ADDR_ANA) ? {8'h0, analog_enable_config_reg} :
    (haddr == plk_pkg::ADDR_CP) ? {8'h0, charge_pump_config_reg} :
    (haddr == plk_pkg::ADDR_AUX) ? {8'h0, aux_serial_trigger_reg} :
    (haddr == plk_pkg::ADDR_STAT) ? {29'h0, irq_stat_reg} :
    (haddr == plk_pkg::ADDR_MASK) ? {29'h0, irq_mask_reg} :
    (haddr == plk_pkg::ADDR_LSTAT) ? {15'h0, hits_reg[15:0],
                                      st_reg == plk_pkg::LK_LOCKED} :
    (haddr == plk_pkg::ADDR_PADCTL) ? {30'h0, pad_ctl_reg} :
    32'h0;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 32'h0;
    end else if (addr_ok && !hwrite) begin
      rdata_reg <= rd_mux;
    end
  end

  // pad steering
  wire pad_en = analog_enable_config_reg[plk_pkg::AN_PAD_EN];
  wire pad_sel = pad_ctl_reg[plk_pkg::PC_LDSEL];
  wire is_locked = st_reg == plk_pkg::LK_LOCKED;
  wire pad_val = pad_sel ? (is_locked | pad_ctl_reg[plk_pkg::PC_GPO]) :
                           serial_data;
  wire pad_drv = pad_en && (pad_sel || serial_drive);

  // analog decode
  wire [2:0] rfb = analog_enable_config_reg[plk_pkg::AN_RFB_LO +: 3];
  wire [2:0] rsy = analog_enable_config_reg[plk_pkg::AN_RSY_LO +: 3];
  wire [6:0] ofs = charge_pump_config_reg[plk_pkg::CP_OFS_LO +: 7];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pad_reg <= 1'b0;
      pad_oe_reg <= 1'b0;
      div2_reg <= 1'b0;
      rfb_reg <= 1'b0;
      rsy_reg <= 1'b0;
      ofs_up_reg <= 7'h0;
      ofs_dn_reg <= 7'h0;
      irq_reg <= 1'b0;
    end else begin
      pad_reg <= pad_val;
      pad_oe_reg <= pad_drv;
      div2_reg <= analog_enable_config_reg[plk_pkg::AN_DIV2];
      rfb_reg <= rfb != plk_pkg::BIAS_OFF;
      rsy_reg <= rsy != plk_pkg::BIAS_OFF;
      ofs_up_reg <= charge_pump_config_reg[plk_pkg::CP_OFS_UP] ?
                    ofs : 7'h0;
      ofs_dn_reg <= charge_pump_config_reg[plk_pkg::CP_OFS_DN] ?
                    ofs : 7'h0;
      irq_reg <= |((irq_stat_reg & ~clr | ev) & irq_mask_reg);
    end
  end

  // outputs
  assign hrdata = rdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = plk_pkg::RESP_OKAY[0];
  assign lock_serial_out_pin = pad_reg;
  assign lock_serial_out_pin_oe = pad_oe_reg;
  assign analog_enable_out = analog_enable_config_reg;
  assign charge_pump_out = charge_pump_config_reg;
  assign aux_trigger_out = aux_serial_trigger_reg;
  assign divide_by_two_on = div2_reg;
  assign rf_buffer_on = rfb_reg;
  assign resync_on = rsy_reg;
  assign pump_down_gain =
    charge_pump_config_reg[plk_pkg::CP_DN_LO +: 7];
  assign pump_up_gain =
    charge_pump_config_reg[plk_pkg::CP_UP_LO +: 7];
  assign offset_up_code = ofs_up_reg;
  assign offset_down_code = ofs_dn_reg;
  assign high_gain_pump_mode = charge_pump_config_reg[plk_pkg::CP_HIK];
  assign relock_req = relock_reg;
  assign locked = st_reg[2];
  assign irq = irq_reg;
endmodule

/* File: plk_top_props.sv */
`timescale 1ns/1ps
module plk_top_props (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // observed outputs
  input wire logic lock_serial_out_pin_oe,
  input wire logic [23:0] analog_enable_out,
  input wire logic [23:0] charge_pump_out,
  input wire logic divide_by_two_on,
  input wire logic rf_buffer_on,
  input wire logic resync_on,
  input wire logic [6:0] pump_down_gain,
  input wire logic [6:0] pump_up_gain,
  input wire logic [6:0] offset_up_code,
  input wire logic [6:0] offset_down_code,
  input wire logic high_gain_pump_mode,
  input wire logic relock_req,
  input wire logic locked,
  input wire logic irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_pad_off: assert property (!analog_enable_out[5] [*2]
    |-> !lock_serial_out_pin_oe) else $error("pad driven while disabled");
  a_div2_follow: assert property (!$past(rst) |->
    divide_by_two_on == $past(analog_enable_out[19]))
    else $error("divide by two mismatch");
  a_rfbuf_bias: assert property (!$past(rst) |->
    rf_buffer_on == ($past(analog_enable_out[14:12]) != 3'h0))
    else $error("rf buffer enable mismatch");
  a_resync_bias: assert property (!$past(rst) |->
    resync_on == ($past(analog_enable_out[17:15]) != 3'h0))
    else $error("resync enable mismatch");
  a_pump_gains: assert property (pump_down_gain == charge_pump_out[6:0]
    && pump_up_gain == charge_pump_out[13:7]) else $error("gain mismatch");
  a_hik_mode: assert property (high_gain_pump_mode == charge_pump_out[23])
    else $error("high gain mode mismatch");
  a_ofs_up: assert property (!$past(rst) |-> offset_up_code ==
    ($past(charge_pump_out[21]) ? $past(charge_pump_out[20:14]) : 7'h0))
    else $error("up offset mismatch");
  a_ofs_down: assert property (!$past(rst) |-> offset_down_code ==
    ($past(charge_pump_out[22]) ? $past(charge_pump_out[20:14]) : 7'h0))
    else $error("down offset mismatch");
  a_relock_pulse: assert property (relock_req |=> !relock_req)
    else $error("relock request too long");
  c_lock: cover property ($rose(locked));
  c_relock: cover property (relock_req);
  c_irq: cover property (irq);
endmodule
bind plk_top plk_top_props plk_top_props_inst (.core_clk, .rst,
  .lock_serial_out_pin_oe, .analog_enable_out, .charge_pump_out,
  .divide_by_two_on, .rf_buffer_on, .resync_on, .pump_down_gain,
  .pump_up_gain, .offset_up_code, .offset_down_code, .high_gain_pump_mode,
  .relock_req, .locked, .irq);

/* File: plk_top_test.sv */
`timescale 1ns/1ps
module plk_top_test;
  logic core_clk, rst, hsel, hwrite, hready, hreadyout, ref_evt, vco_evt;
  logic serial_data, serial_drive, lock_serial_out_pin, lock_serial_out_pin_oe;
  logic divide_by_two_on, rf_buffer_on, resync_on, high_gain_pump_mode;
  logic relock_req, locked, irq, ia;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [6:0] pump_down_gain, pump_up_gain, offset_up_code, offset_down_code;
  int error_cnt, samples_checked, relocks;
  assign hready = hreadyout;
  plk_top plk_top_inst (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp(), .ref_evt,
    .vco_evt, .serial_data, .serial_drive, .lock_serial_out_pin,
    .lock_serial_out_pin_oe, .analog_enable_out(), .charge_pump_out(),
    .aux_trigger_out(), .divide_by_two_on, .rf_buffer_on, .resync_on,
    .pump_down_gain, .pump_up_gain, .offset_up_code, .offset_down_code,
    .high_gain_pump_mode, .relock_req, .locked, .irq);
  initial begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (relock_req === 1'b1) relocks++;
  task print_verdict;
    if (error_cnt == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(rd, e);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // one comparison: vco edge gap+1 cycles after the reference edge
  task hit(input int gap);
    ref_evt <= 1'b1;
    cyc(1);
    ref_evt <= 1'b0;
    cyc(gap);
    vco_evt <= 1'b1;
    cyc(1);
    vco_evt <= 1'b0;
    cyc(4);
  endtask
  task t_reset_map;
    rdc(8'h1c, 32'h0000000d);
    rdc(8'h20, 32'h00c1beff);
    rdc(8'h24, 32'h0040050a);
    rdc(8'h28, 32'h00002205);
    wr(8'h30, 32'hffffffff);
    rdc(8'h30, 32'h0);
  endtask
  task t_fields;
    wr(8'h20, 32'h00cb8fff);
    rdc(8'h20, 32'h00cb8fff);
    wr(8'h24, 32'h00b540ff);
    cyc(2);
    chk(divide_by_two_on, 1);
    chk(rf_buffer_on, 0);
    chk(resync_on, 1);
    chk(pump_down_gain, 32'h7f);
    chk(pump_up_gain, 32'h1);
    chk(offset_up_code, 32'h55);
    chk(offset_down_code, 0);
    chk(high_gain_pump_mode, 1);
    wr(8'h24, 32'h00554000);
    wr(8'h20, 32'h00c1bedf);
    cyc(2);
    chk(offset_up_code, 0);
    chk(offset_down_code, 32'h55);
    chk(high_gain_pump_mode, 0);
    chk(divide_by_two_on, 0);
  endtask
  task t_pad;
    serial_drive <= 1'b1;
    wr(8'h4c, 32'h2);
    cyc(2);
    chk(lock_serial_out_pin_oe, 0);
    wr(8'h20, 32'h00c1beff);
    cyc(2);
    chk(lock_serial_out_pin_oe, 1);
    serial_drive <= 1'b0;
    wr(8'h4c, 32'h0);
    cyc(2);
    chk(lock_serial_out_pin_oe, 0);
    serial_drive <= 1'b1;
    serial_data <= 1'b1;
    cyc(2);
    chk(lock_serial_out_pin_oe, 1);
    chk(lock_serial_out_pin, 1);
    serial_data <= 1'b0;
    cyc(2);
    chk(lock_serial_out_pin, 0);
  endtask
  task t_lock;
    wr(8'h1c, 32'h3c8);
    repeat (4) hit(1);
    chk(locked, 0);
    hit(1);
    chk(locked, 1);
    hit(140);
    chk(locked, 0);
    rdc(8'h40, 32'h3);
    wr(8'h44, 32'h0);
    cyc(2);
    ia = irq;
    wr(8'h44, 32'h7);
    cyc(2);
    chk(ia ^ irq, 1);
    wr(8'h40, 32'h7);
    rdc(8'h40, 32'h0);
    cyc(2);
    chk(irq, 0);
    repeat (4) hit(1);
    chk(locked, 0);
    hit(1);
    chk(locked, 1);
  endtask
  task t_relock;
    wr(8'h1c, 32'h23c8);
    relocks = 0;
    hit(140);
    hit(140);
    chk(relocks, 1);
    repeat (5) hit(1);
    chk(locked, 1);
    wr(8'h1c, 32'h3c0);
    repeat (6) hit(1);
    chk(locked, 0);
  endtask
  initial begin
    rst = 1;
    hsel = 1;
    hwrite = 0;
    htrans = 0;
    hsize = 3'h2;
    haddr = 0;
    hwdata = 0;
    ref_evt = 0;
    vco_evt = 0;
    serial_data = 0;
    serial_drive = 0;
    error_cnt = 0;
    samples_checked = 0;
    relocks = 0;
    cyc(6);
    rst <= 1'b0;
    cyc(1);
    t_reset_map;
    t_fields;
    t_pad;
    t_lock;
    t_relock;
    print_verdict;
  end
  initial begin
    #200000;
    error_cnt++;
    print_verdict;
  end
endmodule

/* File: plk_window.sv */
`timescale 1ns/1ps
// comparison window timer, one-shot or free running
module plk_window #(
  parameter int CW = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // control
  input wire logic ref_evt,
  input wire logic digital,
  input wire logic [2:0] dur,
  input wire logic [1:0] rate,
  input wire logic cont,
  // window
  output logic open_now
);
  logic [CW-1:0] len;
  logic [3:0] pre_reg;
  logic [CW-1:0] cnt_reg;
  logic tick;
  // two ticks per timer cycle, so code 0 (half cycle) is one tick
  assign len = CW'(1) << dur;
  // rate 0 ticks every clock, 3 every eighth
  assign tick = (pre_reg & ((4'h1 << rate) - 4'h1)) == 4'h0;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pre_reg <= 4'h0;
    end else begin
      pre_reg <= pre_reg + 4'h1;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (ref_evt || (cont && cnt_reg == '0)) begin
      cnt_reg <= digital ? len : CW'(plk_pkg::ANA_WIN_CYC);
    end else if (cnt_reg != '0 && (tick || !digital)) begin
      cnt_reg <= cnt_reg - CW'(1);
    end
  end
  assign open_now = (cnt_reg != '0) || (cont && digital);
endmodule
